// ===== vnc_pkg.sv
package vnc_pkg;
    // register byte offsets
    localparam logic [7:0] VNC_CTRL_OFS  = 8'h00;
    localparam logic [7:0] VNC_SCALE_OFS = 8'h04;
    localparam logic [7:0] VNC_BAND_OFS  = 8'h08;
    localparam logic [7:0] VNC_BPCNT_OFS = 8'h0c;
    localparam logic [7:0] VNC_BPWR_OFS  = 8'h10;
    localparam logic [7:0] VNC_SUBC_OFS  = 8'h14;
    localparam logic [7:0] VNC_STAT_OFS  = 8'h18;
    // control register fields
    localparam int VNC_FMT_POS    = 0;
    localparam int VNC_HALF_POS   = 1;
    localparam int VNC_METHOD_POS = 2;
    localparam int VNC_DSPOL_POS  = 5;
    localparam int VNC_USPOL_POS  = 6;
    localparam int VNC_DSLIM_POS  = 8;
    localparam int VNC_USLIM_POS  = 16;
    // scale register fields
    localparam int VNC_RXSF_POS  = 0;
    localparam int VNC_TXSF_POS  = 8;
    localparam int VNC_TXPSD_POS = 16;
    // band register fields
    localparam int VNC_BLO_POS = 0;
    localparam int VNC_BHI_POS = 16;
    // breakpoint write fields
    localparam int VNC_BPIDX_POS = 0;
    localparam int VNC_BPT_POS   = 8;
    localparam int VNC_BPPSD_POS = 24;
    // subcarrier result fields
    localparam int VNC_BUSY_POS  = 31;
    localparam int VNC_VALID_POS = 30;
    localparam int VNC_ZERO_POS  = 29;
    localparam int VNC_OOB_POS   = 28;
    // status fields
    localparam int VNC_STDS_POS = 8;
    localparam int VNC_STUS_POS = 10;
    // sizes and limits
    localparam int             VNC_NBP      = 16;
    localparam int             VNC_BEARERS  = 2;
    localparam logic [7:0]     VNC_PSD_MAX  = 8'hc8;
    localparam logic [4:0]     VNC_LIM_MIN  = 5'h05;
    localparam logic [4:0]     VNC_LIM_MAX  = 5'h1f;
    localparam logic [2:0]     VNC_METHOD_FIXED  = 3'h3;
    localparam logic [2:0]     VNC_METHOD_SCALED = 3'h4;
    // levels in half-dB units: top is -40 dBm/Hz, bottom -140 dBm/Hz
    localparam logic signed [10:0] VNC_TOP_LVL = -11'sh050;
    localparam logic signed [10:0] VNC_BOT_LVL = -11'sh118;
    // reset values
    localparam logic       VNC_FMT_RST    = 1'h0;
    localparam logic [2:0] VNC_METHOD_RST = 3'h3;
    localparam logic [4:0] VNC_LIM_RST    = 5'h0a;
    localparam logic [7:0] VNC_SF_RST     = 8'h00;
    localparam logic [7:0] VNC_PSD_RST    = 8'h00;
    localparam logic [4:0] VNC_BPCNT_RST  = 5'h00;

    typedef struct packed {
        logic [11:0] t;
        logic [7:0]  psd;
    } vnc_bp_t;

    typedef enum logic [1:0] {VNC_IDLE, VNC_SCAN, VNC_DIV} vnc_state_t;
endpackage

// ===== vnc_divider.sv
`timescale 1ns/1ps
// serial signed-by-unsigned divider, one quotient bit per cycle
module vnc_divider (
    input  wire logic               mclk,
    input  wire logic               arst_n,
    input  wire logic               start,
    input  wire logic signed [24:0] num,
    input  wire logic        [12:0] den,
    output logic                    done,
    output logic signed      [10:0] quot
);
    logic [13:0] remQ, remD;
    logic [24:0] qQ, qD;
    logic [12:0] denQ, denD;
    logic [4:0]  cntQ, cntD;
    logic        busyQ, busyD, negQ, negD, doneQ, doneD;
    logic [13:0] shifted;

    always_comb begin
        remD    = remQ;
        qD      = qQ;
        denD    = denQ;
        cntD    = cntQ;
        busyD   = busyQ;
        negD    = negQ;
        doneD   = 1'b0;
        shifted = {remQ[12:0], qQ[24]};
        if (start && !busyQ) begin
            busyD = 1'b1;
            negD  = num[24];
            qD    = num[24] ? 25'(-num) : 25'(num);
            remD  = 14'h0000;
            denD  = den;
            cntD  = 5'h00;
        end else if (busyQ) begin
            if (shifted >= {1'b0, denQ} && denQ != 13'h0000) begin
                remD = 14'(shifted - {1'b0, denQ});
                qD   = {qQ[23:0], 1'b1};
            end else begin
                remD = shifted;
                qD   = {qQ[23:0], 1'b0};
            end
            cntD = 5'(cntQ + 5'h01);
            if (cntQ == 5'h18) begin
                busyD = 1'b0;
                doneD = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            remQ  <= 14'h0000;
            qQ    <= 25'h0000000;
            denQ  <= 13'h0000;
            cntQ  <= 5'h00;
            busyQ <= 1'b0;
            negQ  <= 1'b0;
            doneQ <= 1'b0;
        end else begin
            remQ  <= remD;
            qQ    <= qD;
            denQ  <= denD;
            cntQ  <= cntD;
            busyQ <= busyD;
            negQ  <= negD;
            doneQ <= doneD;
        end
    end

    assign done = doneQ;
    assign quot = negQ ? -$signed(qQ[10:0]) : $signed(qQ[10:0]);
endmodule

// ===== vnc_config.sv
// Chosen here: the APB interface to the registers and the address map.
`timescale 1ns/1ps
// Overview of operation
// - scale format takes only 0, or 1 if supported
// - format starts at 0; 1 only when supported
// - link state changes never touch the format
// - half spacing: odd indices down, first up
// - psd code 0..200 maps -40..-140 dBm/Hz
// - codes 201..255 mean zero noise power
// - storage for sixteen breakpoints per band
// - ignore breakpoints outside the upstream band
// - per subcarrier linear interpolation in dB
// - method 3 raw breakpoints, method 4 scaled
// - scale factors signed, half-dB steps
// - upstream control level is level plus factor
// - downstream level plus factor, clamped -140..-40
// - downstream policy copies config, remote fallback
// - upstream policy copies config, local fallback
// - errored-second limit valid from 5 to 31
// - thresholds pass through unchanged
module vnc_config #(
    parameter bit FMT1_SUPPORTED = 1'b1
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [1:0]  remoteUnsupported,
    input  wire logic [1:0]  localUnsupported,
    output logic             histScaleFormat,
    output logic      [7:0]  txCtrlPsdCode,
    output logic      [1:0]  dsPolicy,
    output logic      [1:0]  usPolicy,
    output logic      [4:0]  dsErroredLimit,
    output logic      [4:0]  usErroredLimit
);
    localparam logic signed [10:0] VNC_TOP = vnc_pkg::VNC_TOP_LVL;

    function automatic logic signed [10:0] psdLevel(input logic [7:0] c);
        return 11'(VNC_TOP - $signed({3'h0, c}));
    endfunction
    function automatic logic signed [10:0] sfExt(input logic [7:0] s);
        return $signed({{3{s[7]}}, s});
    endfunction
    function automatic logic [12:0] evenT(input logic [11:0] t, input logic first,
                                          input logic half);
        logic [12:0] w;
        w = {1'b0, t};
        if (half && first) w = 13'(w + 13'h0001) & 13'h1ffe;
        else if (half) w = w & 13'h1ffe;
        return w;
    endfunction

    // register bank
    logic                 fmtQ, fmtD, halfQ, halfD, dsCfgQ, dsCfgD, usCfgQ, usCfgD;
    logic [2:0]           methodQ, methodD;
    logic [4:0]           dsLimQ, dsLimD, usLimQ, usLimD, bpCntQ, bpCntD;
    logic [7:0]           rxSfQ, rxSfD, txSfQ, txSfD, txPsdQ, txPsdD;
    logic [11:0]          bandLoQ, bandLoD, bandHiQ, bandHiD, subcQ, subcD;
    logic [3:0]           bpSelQ, bpSelD;
    vnc_pkg::vnc_bp_t     bpQ [vnc_pkg::VNC_NBP];
    vnc_pkg::vnc_bp_t     bpD [vnc_pkg::VNC_NBP];
    logic [31:0]          prdataD;
    logic                 preadyD, pslverrD, wrEn, setup, mapped;
    logic                 startReq;

    assign setup = psel && penable && !pready;
    assign wrEn  = psel && penable && pready && pwrite;

    always_comb begin
        mapped = 1'b1;
        unique case (paddr)
            vnc_pkg::VNC_CTRL_OFS, vnc_pkg::VNC_SCALE_OFS, vnc_pkg::VNC_BAND_OFS,
            vnc_pkg::VNC_BPCNT_OFS, vnc_pkg::VNC_BPWR_OFS, vnc_pkg::VNC_SUBC_OFS,
            vnc_pkg::VNC_STAT_OFS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // interpolation engine state
    vnc_pkg::vnc_state_t  stQ, stD;
    logic [3:0]           segQ, segD;
    logic signed [10:0]   lvAQ, lvAD, lvBQ, lvBD, resQ, resD;
    logic                 validQ, validD, zeroQ, zeroD, oobQ, oobD, divStart, divDone;
    logic [12:0]          xPos, ta, tb;
    logic signed [10:0]   segA, segB, diff;
    logic signed [24:0]   divNum;
    logic [12:0]          divDen;
    logic signed [10:0]   divQuot;

    always_comb begin
        fmtD = fmtQ; halfD = halfQ; methodD = methodQ;
        dsCfgD = dsCfgQ; usCfgD = usCfgQ; dsLimD = dsLimQ; usLimD = usLimQ;
        rxSfD = rxSfQ; txSfD = txSfQ; txPsdD = txPsdQ;
        bandLoD = bandLoQ; bandHiD = bandHiQ; bpCntD = bpCntQ;
        bpSelD = bpSelQ; subcD = subcQ; bpD = bpQ;
        startReq = 1'b0;
        if (wrEn) begin
            unique case (paddr)
                vnc_pkg::VNC_CTRL_OFS: begin
                    if (!pwdata[vnc_pkg::VNC_FMT_POS] || FMT1_SUPPORTED) begin
                        fmtD = pwdata[vnc_pkg::VNC_FMT_POS];
                    end
                    halfD   = pwdata[vnc_pkg::VNC_HALF_POS];
                    methodD = pwdata[vnc_pkg::VNC_METHOD_POS +: 3];
                    dsCfgD  = pwdata[vnc_pkg::VNC_DSPOL_POS];
                    usCfgD  = pwdata[vnc_pkg::VNC_USPOL_POS];
                    if (pwdata[vnc_pkg::VNC_DSLIM_POS +: 5] >= vnc_pkg::VNC_LIM_MIN) begin
                        dsLimD = pwdata[vnc_pkg::VNC_DSLIM_POS +: 5];
                    end
                    if (pwdata[vnc_pkg::VNC_USLIM_POS +: 5] >= vnc_pkg::VNC_LIM_MIN) begin
                        usLimD = pwdata[vnc_pkg::VNC_USLIM_POS +: 5];
                    end
                end
                vnc_pkg::VNC_SCALE_OFS: begin
                    rxSfD  = pwdata[vnc_pkg::VNC_RXSF_POS +: 8];
                    txSfD  = pwdata[vnc_pkg::VNC_TXSF_POS +: 8];
                    txPsdD = pwdata[vnc_pkg::VNC_TXPSD_POS +: 8];
                end
                vnc_pkg::VNC_BAND_OFS: begin
                    bandLoD = pwdata[vnc_pkg::VNC_BLO_POS +: 12];
                    bandHiD = pwdata[vnc_pkg::VNC_BHI_POS +: 12];
                end
                vnc_pkg::VNC_BPCNT_OFS: begin
                    if (pwdata[4:0] <= 5'h10) bpCntD = pwdata[4:0];
                end
                vnc_pkg::VNC_BPWR_OFS: begin
                    bpSelD = pwdata[vnc_pkg::VNC_BPIDX_POS +: 4];
                    if (pwdata[vnc_pkg::VNC_BPT_POS +: 12] >= bandLoQ &&
                        pwdata[vnc_pkg::VNC_BPT_POS +: 12] <= bandHiQ) begin
                        bpD[bpSelD].t   = pwdata[vnc_pkg::VNC_BPT_POS +: 12];
                        bpD[bpSelD].psd = pwdata[vnc_pkg::VNC_BPPSD_POS +: 8];
                    end
                end
                vnc_pkg::VNC_SUBC_OFS: begin
                    if (stQ == vnc_pkg::VNC_IDLE) begin
                        subcD    = pwdata[11:0];
                        startReq = 1'b1;
                    end
                end
                default: ;
            endcase
        end
    end

    // endpoint levels of the current segment; method 4 shifts both by the factor
    always_comb begin
        xPos = halfQ ? {subcQ, 1'b0} : {1'b0, subcQ};
        ta   = evenT(bpQ[segQ].t, segQ == 4'h0, halfQ);
        tb   = evenT(bpQ[4'(segQ + 4'h1)].t, 1'b0, halfQ);
        segA = psdLevel(bpQ[segQ].psd);
        segB = psdLevel(bpQ[4'(segQ + 4'h1)].psd);
        if (methodQ == vnc_pkg::VNC_METHOD_SCALED) begin
            segA = 11'(segA + sfExt(rxSfQ));
            segB = 11'(segB + sfExt(rxSfQ));
        end
        diff   = 11'(lvBQ - lvAQ);
        divNum = 25'(diff * $signed({1'b0, 13'(xPos - ta)}));
        divDen = 13'(tb - ta);
    end

    always_comb begin
        stD = stQ; segD = segQ; lvAD = lvAQ; lvBD = lvBQ; resD = resQ;
        validD = validQ; zeroD = zeroQ; oobD = oobQ; divStart = 1'b0;
        unique case (stQ)
            vnc_pkg::VNC_IDLE: begin
                if (startReq) begin
                    validD = 1'b0; zeroD = 1'b0; oobD = 1'b0;
                    segD = 4'h0;
                    stD  = vnc_pkg::VNC_SCAN;
                end
            end
            vnc_pkg::VNC_SCAN: begin
                // relies on strictly increasing indices from software
                if ({1'b0, segQ} + 5'h01 >= bpCntQ ||
                    subcQ < bandLoQ || subcQ > bandHiQ) begin
                    oobD = 1'b1; validD = 1'b1;
                    stD  = vnc_pkg::VNC_IDLE;
                end else if (xPos >= ta && xPos <= tb) begin
                    lvAD = segA;
                    lvBD = segB;
                    if (bpQ[segQ].psd > vnc_pkg::VNC_PSD_MAX ||
                        bpQ[4'(segQ + 4'h1)].psd > vnc_pkg::VNC_PSD_MAX) begin
                        zeroD = 1'b1; validD = 1'b1;
                        stD   = vnc_pkg::VNC_IDLE;
                    end else begin
                        stD = vnc_pkg::VNC_DIV;
                    end
                end else begin
                    segD = 4'(segQ + 4'h1);
                end
            end
            vnc_pkg::VNC_DIV: begin
                // no restart in the done cycle, or a stale job would still run
                divStart = !divDone;
                if (divDone) begin
                    resD   = 11'(lvAQ + divQuot);
                    validD = 1'b1;
                    stD    = vnc_pkg::VNC_IDLE;
                end
            end
            default: stD = vnc_pkg::VNC_IDLE;
        endcase
    end

    vnc_divider u_div (
        .mclk   (mclk),
        .arst_n (arst_n),
        .start  (divStart),
        .num    (divNum),
        .den    (divDen),
        .done   (divDone),
        .quot   (divQuot)
    );

    // signalled values, each from a flip-flop
    logic signed [10:0] txSum, txClamp;
    logic [7:0]         txCodeD;
    logic [1:0]         dsPolD, usPolD;
    always_comb begin
        txSum   = 11'(psdLevel(txPsdQ) + sfExt(txSfQ));
        txClamp = txSum;
        if (txSum < vnc_pkg::VNC_BOT_LVL) txClamp = vnc_pkg::VNC_BOT_LVL;
        if (txSum > VNC_TOP) txClamp = VNC_TOP;
        txCodeD = (txPsdQ > vnc_pkg::VNC_PSD_MAX) ? txPsdQ : 8'(VNC_TOP - txClamp);
        dsPolD  = {2{dsCfgQ}} & ~remoteUnsupported;
        usPolD  = {2{usCfgQ}} & ~localUnsupported;
        prdataD = 32'h00000000;
        unique case (paddr)
            vnc_pkg::VNC_CTRL_OFS: prdataD = {11'h000, usLimQ, 3'h0, dsLimQ, 1'b0, usCfgQ,
                                             dsCfgQ, methodQ, halfQ, fmtQ};
            vnc_pkg::VNC_SCALE_OFS: prdataD = {8'h00, txPsdQ, txSfQ, rxSfQ};
            vnc_pkg::VNC_BAND_OFS: prdataD = {4'h0, bandHiQ, 4'h0, bandLoQ};
            vnc_pkg::VNC_BPCNT_OFS: prdataD = {27'h0000000, bpCntQ};
            vnc_pkg::VNC_BPWR_OFS: prdataD = {bpQ[bpSelQ].psd, 4'h0, bpQ[bpSelQ].t,
                                             4'h0, bpSelQ};
            vnc_pkg::VNC_SUBC_OFS: prdataD = {stQ != vnc_pkg::VNC_IDLE, validQ, zeroQ, oobQ,
                                             17'h00000, resQ};
            vnc_pkg::VNC_STAT_OFS: prdataD = {20'h00000, usPolicy, dsPolicy, txCtrlPsdCode};
            default: prdataD = 32'h00000000;
        endcase
        preadyD  = setup;
        pslverrD = setup && !mapped;
    end

    // only reset clears these; no link-state input exists
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            fmtQ <= vnc_pkg::VNC_FMT_RST;
            halfQ <= 1'b0; methodQ <= vnc_pkg::VNC_METHOD_RST;
            dsCfgQ <= 1'b0; usCfgQ <= 1'b0;
            dsLimQ <= vnc_pkg::VNC_LIM_RST; usLimQ <= vnc_pkg::VNC_LIM_RST;
            rxSfQ <= vnc_pkg::VNC_SF_RST; txSfQ <= vnc_pkg::VNC_SF_RST;
            txPsdQ <= vnc_pkg::VNC_PSD_RST;
            bandLoQ <= 12'h000; bandHiQ <= 12'hfff; bpCntQ <= vnc_pkg::VNC_BPCNT_RST;
            bpSelQ <= 4'h0; subcQ <= 12'h000;
            for (int k = 0; k < vnc_pkg::VNC_NBP; k++) bpQ[k] <= '0;
            stQ <= vnc_pkg::VNC_IDLE; segQ <= 4'h0;
            lvAQ <= 11'sh000; lvBQ <= 11'sh000; resQ <= 11'sh000;
            validQ <= 1'b0; zeroQ <= 1'b0; oobQ <= 1'b0;
            prdata <= 32'h00000000; pready <= 1'b0; pslverr <= 1'b0;
            histScaleFormat <= 1'b0; txCtrlPsdCode <= 8'h00;
            dsPolicy <= 2'h0; usPolicy <= 2'h0;
            dsErroredLimit <= vnc_pkg::VNC_LIM_RST; usErroredLimit <= vnc_pkg::VNC_LIM_RST;
        end else begin
            fmtQ <= fmtD; halfQ <= halfD; methodQ <= methodD;
            dsCfgQ <= dsCfgD; usCfgQ <= usCfgD; dsLimQ <= dsLimD; usLimQ <= usLimD;
            rxSfQ <= rxSfD; txSfQ <= txSfD; txPsdQ <= txPsdD;
            bandLoQ <= bandLoD; bandHiQ <= bandHiD; bpCntQ <= bpCntD;
            bpSelQ <= bpSelD; subcQ <= subcD; bpQ <= bpD;
            stQ <= stD; segQ <= segD; lvAQ <= lvAD; lvBQ <= lvBD; resQ <= resD;
            validQ <= validD; zeroQ <= zeroD; oobQ <= oobD;
            prdata <= prdataD; pready <= preadyD; pslverr <= pslverrD;
            histScaleFormat <= fmtQ;
            txCtrlPsdCode <= txCodeD;
            dsPolicy <= dsPolD; usPolicy <= usPolD;
            dsErroredLimit <= dsLimQ;
            usErroredLimit <= usLimQ;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);

    sequence sCtrlWrite;
        wrEn && paddr == vnc_pkg::VNC_CTRL_OFS;
    endsequence
    sequence sSubcStart;
        wrEn && paddr == vnc_pkg::VNC_SUBC_OFS && stQ == vnc_pkg::VNC_IDLE;
    endsequence

    a_fmt_legal: assert property (histScaleFormat |-> FMT1_SUPPORTED)
        else $error("format 1 reported without support");
    a_fmt_hold: assert property (!(wrEn && paddr == vnc_pkg::VNC_CTRL_OFS) |=> $stable(fmtQ))
        else $error("scale format changed without a write");
    a_fmt_follow: assert property (sCtrlWrite ##1 1'b1 |=> histScaleFormat == $past(fmtQ))
        else $error("format output not following register");
    a_ds_fallback: assert property (##1 dsPolicy == $past({2{dsCfgQ}} & ~remoteUnsupported))
        else $error("downstream policy fallback wrong");
    a_us_fallback: assert property (##1 usPolicy == $past({2{usCfgQ}} & ~localUnsupported))
        else $error("upstream policy fallback wrong");
    a_limit_range: assert property (dsErroredLimit >= vnc_pkg::VNC_LIM_MIN &&
                                    usErroredLimit >= vnc_pkg::VNC_LIM_MIN)
        else $error("errored limit below range");
    a_limit_copy: assert property (##1 dsErroredLimit == $past(dsLimQ))
        else $error("downstream limit altered");
    a_tx_clamp: assert property (txPsdQ <= vnc_pkg::VNC_PSD_MAX |=>
                                 txCtrlPsdCode <= vnc_pkg::VNC_PSD_MAX)
        else $error("downstream control level outside clamp");
    a_zero_flag: assert property (stQ == vnc_pkg::VNC_SCAN && stD == vnc_pkg::VNC_IDLE &&
                                  !oobD |=> zeroQ)
        else $error("zero-power endpoint not flagged");
    a_interp_done: assert property (sSubcStart |-> ##[2:50] stQ == vnc_pkg::VNC_IDLE)
        else $error("interpolation did not finish");
    a_interp_bound: assert property ($rose(validQ) && !zeroQ && !oobQ |->
        (resQ >= lvAQ && resQ <= lvBQ) || (resQ <= lvAQ && resQ >= lvBQ))
        else $error("interpolated level outside its segment");
endmodule

// ===== vnc_remote_model.sv
`timescale 1ns/1ps
// far-side transceiver: reports per-bearer capability for downstream policy 1
module vnc_remote_model (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [1:0] refuseBearer,
    output logic      [1:0] remoteUnsupported
);
    logic [1:0] report_q;
    logic [1:0] report_d;

    // capability follows refuseBearer every cycle, one clock late; a refused bearer stays flagged until changed
    always_comb begin
        report_d = refuseBearer;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            report_q <= 2'h0;
        end else begin
            report_q <= report_d;
        end
    end

    assign remoteUnsupported = report_q;
endmodule

// ===== test_virtual_noise_config.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin nFail++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end
module test_virtual_noise_config;
    logic        mclk;
    logic        arst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  refuseBearer;
    logic [1:0]  remoteUnsupported;
    logic [1:0]  localUnsupported;
    logic        histScaleFormat;
    logic [7:0]  txCtrlPsdCode;
    logic [1:0]  dsPolicy;
    logic [1:0]  usPolicy;
    logic [4:0]  dsErroredLimit;
    logic [4:0]  usErroredLimit;
    logic [31:0] r;
    logic        e;
    int          nFail;
    int          checked;
    logic [7:0]  tbl [4][3];

    vnc_config i_dut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .remoteUnsupported(remoteUnsupported),
        .localUnsupported(localUnsupported), .histScaleFormat(histScaleFormat),
        .txCtrlPsdCode(txCtrlPsdCode), .dsPolicy(dsPolicy), .usPolicy(usPolicy),
        .dsErroredLimit(dsErroredLimit), .usErroredLimit(usErroredLimit));
    vnc_remote_model i_remote (.mclk(mclk), .arst_n(arst_n), .refuseBearer(refuseBearer),
        .remoteUnsupported(remoteUnsupported));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_of_test();
        if (nFail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk);
        end
        if (n >= 20) nFail++;
        r = prdata; e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl(input logic h, input logic [2:0] m,
        input logic p, input logic [4:0] dl, input logic [4:0] ul);
        return {11'h0, ul, 3'h0, dl, 1'h0, p, p, m, h, 1'b1};
    endfunction

    task automatic settle();
        repeat (3) @(posedge mclk);
        #1;
    endtask

    task automatic subc(input logic [11:0] i);
        int n;
        n = 0;
        apb(1'b1, vnc_pkg::VNC_SUBC_OFS, {20'h0, i});
        apb(1'b0, vnc_pkg::VNC_SUBC_OFS, 32'h0);
        while (r[31] !== 1'b0 && n < 60) begin
            n++;
            apb(1'b0, vnc_pkg::VNC_SUBC_OFS, 32'h0);
        end
        `CHK(r[30], 1'b1)
    endtask

    initial begin
        #(25ns * 20000);
        nFail++;
        end_of_test();
    end

    initial begin
        nFail = 0; checked = 0; arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
        paddr = 8'h00; pwdata = 32'h0; refuseBearer = 2'h0; localUnsupported = 2'h0;
        repeat (2) @(posedge mclk);
        arst_n <= 1'b1;
        apb(1'b0, vnc_pkg::VNC_CTRL_OFS, 32'h0);
        `CHK(r, 32'h000a0a0c)
        `CHK(histScaleFormat, 1'b0)
        apb(1'b1, vnc_pkg::VNC_CTRL_OFS, ctrl(1'b0, 3'h3, 1'b1, 5'h05, 5'h1f));
        settle();
        `CHK(histScaleFormat, 1'b1)
        `CHK({dsErroredLimit, usErroredLimit}, {5'h05, 5'h1f})
        `CHK({dsPolicy, usPolicy}, 4'hf)
        refuseBearer <= 2'h1; localUnsupported <= 2'h2;
        settle();
        `CHK({dsPolicy, usPolicy}, 4'h9)
        refuseBearer <= 2'h0; localUnsupported <= 2'h0;
        apb(1'b1, vnc_pkg::VNC_CTRL_OFS, ctrl(1'b0, 3'h3, 1'b0, 5'h04, 5'h00));
        settle();
        `CHK({dsErroredLimit, usErroredLimit, dsPolicy}, {5'h05, 5'h1f, 2'h0})
        apb(1'b0, 8'h1c, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
        apb(1'b1, vnc_pkg::VNC_BAND_OFS, {4'h0, 12'h064, 4'h0, 12'h00a});
        apb(1'b1, vnc_pkg::VNC_BPCNT_OFS, 32'h2);
        apb(1'b1, vnc_pkg::VNC_BPWR_OFS, {8'h00, 4'h0, 12'h00a, 8'h00});
        apb(1'b1, vnc_pkg::VNC_BPWR_OFS, {8'h50, 4'h0, 12'h033, 8'h01});
        apb(1'b1, vnc_pkg::VNC_BPWR_OFS, {8'h00, 4'h0, 12'h0c8, 8'h01});
        subc(12'h033);
        `CHK(r[10:0], -11'sd160)
        apb(1'b1, vnc_pkg::VNC_SCALE_OFS, 32'h0000000a);
        apb(1'b1, vnc_pkg::VNC_CTRL_OFS, ctrl(1'b0, 3'h4, 1'b0, 5'h05, 5'h1f));
        subc(12'h033);
        `CHK(r[10:0], -11'sd150)
        apb(1'b1, vnc_pkg::VNC_CTRL_OFS, ctrl(1'b1, 3'h3, 1'b0, 5'h05, 5'h1f));
        subc(12'h00f);
        `CHK(r[10:0], -11'sd120)
        foreach (tbl[k]) begin
            apb(1'b1, vnc_pkg::VNC_BPWR_OFS, {(k < 2) ? 8'hc9 : 8'hff, 4'h0, 12'h033, 8'h01});
            subc(12'h014);
            `CHK(r[29], 1'b1)
        end
        tbl = '{'{8'h32, 8'h00, 8'h32}, '{8'h10, 8'h28, 8'h00},
                '{8'h64, 8'h80, 8'hc8}, '{8'h0a, 8'hfc, 8'h0e}};
        foreach (tbl[k]) begin
            apb(1'b1, vnc_pkg::VNC_SCALE_OFS, {8'h00, tbl[k][0], tbl[k][1], 8'h00});
            settle();
            `CHK(txCtrlPsdCode, tbl[k][2])
            apb(1'b0, vnc_pkg::VNC_STAT_OFS, 32'h0);
            `CHK(r[7:0], tbl[k][2])
        end
        end_of_test();
    end
endmodule
